// File: src/acc_pkg.sv
package acc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] RUN_CTRL_IDX = 8'h61;
  localparam logic [7:0] CFG_A_IDX = 8'h62;
  localparam logic [7:0] CFG_B_IDX = 8'h65;
  localparam logic [7:0] AVG_IDX = 8'h68;
  localparam logic [7:0] LINK_CTRL_IDX = 8'h70;
  localparam logic [7:0] STATUS_IDX = 8'h71;
  localparam logic [7:0] FAULT_IDX = 8'h72;

  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] RUN_CTRL_ADDR = {2'b00, RUN_CTRL_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] CFG_A_ADDR = {2'b00, CFG_A_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] CFG_B_ADDR = {2'b00, CFG_B_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] AVG_ADDR = {2'b00, AVG_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] LINK_CTRL_ADDR = {2'b00, LINK_CTRL_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] STATUS_ADDR = {2'b00, STATUS_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] FAULT_ADDR = {2'b00, FAULT_IDX, 2'b00};

  localparam logic [7:0] RUN_CTRL_RST = 8'h01;
  localparam logic [7:0] CFG_A_RST = 8'h01;
  localparam logic [7:0] CFG_B_RST = 8'h01;
  localparam logic [7:0] AVG_RST = 8'h61;
  localparam logic [7:0] LINK_CTRL_RST = 8'h00;

  localparam int RUN_BIT = 0;
  localparam int FG_BIT = 0;
  localparam int BG_BIT = 1;
  localparam int FG_OS_BIT = 2;
  localparam int BG_OS_BIT = 3;
  localparam int OFFSET_REFERENCE_SELECT_BIT = 2;
  localparam int OFFSET_AVERAGING_AMOUNT_LSB = 4;
  localparam int LIN_AVG_LSB = 0;
  localparam int AVG_W = 3;
  localparam int LINK_BIT = 0;

  // Fault flag positions
  localparam int FLT_CFG_WHILE_RUN = 0;
  localparam int FLT_LINK_BEFORE_RUN = 1;
  localparam int FLT_RUN_OFF_LINK_ON = 2;
  localparam int FLT_OFFSET_REFERENCE_SELECT_NO_BG = 3;
  localparam int FLT_W = 4;

  typedef struct packed {
    logic fg;
    logic bg;
    logic fg_os;
    logic bg_os;
    logic offset_reference_select;
    logic [AVG_W-1:0] offset_averaging_amount;
    logic [AVG_W-1:0] lin_avg;
  } acc_cfg_t;

  typedef struct packed {
    logic values_reset;
    logic fg_run;
    logic fg_offset;
    logic bg_run;
    logic bg_offset;
    logic ref_spare;
  } acc_engine_t;

  typedef enum logic [2:0] {
    SEQ_HOLD,
    SEQ_RESET_VALUES,
    SEQ_FOREGROUND,
    SEQ_BACKGROUND,
    SEQ_DONE
  } acc_seq_state_t;

endpackage : acc_pkg

// File: src/acc_cal_sequencer.sv
module acc_cal_sequencer
  import acc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input acc_cfg_t cfg,
  input wire logic fg_done_in,
  output acc_engine_t engine_ctrl,
  output acc_cfg_t cfg_latched,
  output acc_seq_state_t state,
  output logic fg_done
);

  acc_seq_state_t state_q;
  acc_seq_state_t state_d;
  acc_cfg_t cfg_q;
  logic fg_done_q;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      SEQ_HOLD: if (run) state_d = SEQ_RESET_VALUES;
      SEQ_RESET_VALUES: state_d = cfg_q.fg ? SEQ_FOREGROUND : (cfg_q.bg ? SEQ_BACKGROUND : SEQ_DONE);
      SEQ_FOREGROUND: if (fg_done_in) state_d = cfg_q.bg ? SEQ_BACKGROUND : SEQ_DONE;
      SEQ_BACKGROUND: state_d = SEQ_BACKGROUND;
      SEQ_DONE: state_d = SEQ_DONE;
    endcase
    if (!run) state_d = SEQ_HOLD;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) state_q <= SEQ_HOLD;
    else state_q <= state_d;
  end

  // Settings are frozen at the run edge so later writes cannot disturb a sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cfg_q <= '0;
    else if (state_q == SEQ_HOLD && run) cfg_q <= cfg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) fg_done_q <= 1'b0;
    else if (state_d == SEQ_HOLD || state_d == SEQ_RESET_VALUES) fg_done_q <= 1'b0;
    // Done only when foreground was skipped or has really finished
    else if ((state_q == SEQ_RESET_VALUES && !cfg_q.fg) ||
             (state_q == SEQ_FOREGROUND && fg_done_in)) fg_done_q <= 1'b1;
  end

  always_comb begin
    engine_ctrl = '0;
    engine_ctrl.values_reset = (state_q == SEQ_RESET_VALUES);
    engine_ctrl.fg_run = (state_q == SEQ_FOREGROUND);
    engine_ctrl.fg_offset = engine_ctrl.fg_run && cfg_q.fg_os;
    engine_ctrl.bg_run = (state_q == SEQ_BACKGROUND);
    engine_ctrl.bg_offset = engine_ctrl.bg_run && cfg_q.bg_os;
    // Spare reference whenever the reference select and background are both set in the latched settings, in any state; mid-code otherwise
    engine_ctrl.ref_spare = cfg_q.offset_reference_select && cfg_q.bg;
  end

  assign cfg_latched = cfg_q;
  assign state = state_q;
  assign fg_done = fg_done_q;

endmodule : acc_cal_sequencer

// File: src/acc_calibration_control.sv
module acc_calibration_control
  import acc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fg_done_in,
  output logic engine_hold,
  output logic divider_reset,
  output logic serial_link_enable,
  output acc_engine_t engine_ctrl,
  output acc_cfg_t engine_cfg
);

  logic [7:0] run_ctrl_q;
  logic [7:0] cfg_a_q;
  logic [7:0] cfg_b_q;
  logic [7:0] avg_q;
  logic [7:0] link_ctrl_q;
  logic [FLT_W-1:0] fault_q;
  logic [31:0] prdata_q;
  logic engine_hold_q;
  logic divider_reset_q;
  logic link_out_q;

  logic setup;
  logic access;
  logic wr;
  logic mapped;
  logic [7:0] wbyte;
  logic run;
  logic link;
  acc_cfg_t cfg_live;
  acc_seq_state_t seq_state;
  logic seq_fg_done;
  logic [31:0] rd_mux;
  logic [FLT_W-1:0] fault_set;

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign wr = access && pwrite && pstrb[0];
  assign wbyte = pwdata[7:0];
  assign run = run_ctrl_q[RUN_BIT];
  assign link = link_ctrl_q[LINK_BIT];

  always_comb begin
    unique case (paddr)
      RUN_CTRL_ADDR, CFG_A_ADDR, CFG_B_ADDR, AVG_ADDR, LINK_CTRL_ADDR, STATUS_ADDR, FAULT_ADDR: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Zero-wait slave; read data is captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata = prdata_q;

  // Reserved bits are stored as written so read-back shows what software wrote
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) run_ctrl_q <= RUN_CTRL_RST;
    else if (wr && paddr == RUN_CTRL_ADDR) run_ctrl_q <= wbyte;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cfg_a_q <= CFG_A_RST;
    else if (wr && paddr == CFG_A_ADDR) cfg_a_q <= wbyte;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cfg_b_q <= CFG_B_RST;
    else if (wr && paddr == CFG_B_ADDR) cfg_b_q <= wbyte;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) avg_q <= AVG_RST;
    else if (wr && paddr == AVG_ADDR) avg_q <= wbyte;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) link_ctrl_q <= LINK_CTRL_RST;
    else if (wr && paddr == LINK_CTRL_ADDR) link_ctrl_q <= wbyte;
  end

  always_comb begin
    cfg_live.fg = cfg_a_q[FG_BIT];
    cfg_live.bg = cfg_a_q[BG_BIT];
    cfg_live.fg_os = cfg_a_q[FG_OS_BIT];
    cfg_live.bg_os = cfg_a_q[BG_OS_BIT];
    cfg_live.offset_reference_select = cfg_b_q[OFFSET_REFERENCE_SELECT_BIT];
    cfg_live.offset_averaging_amount = avg_q[OFFSET_AVERAGING_AMOUNT_LSB +: AVG_W];
    cfg_live.lin_avg = avg_q[LIN_AVG_LSB +: AVG_W];
  end

  // Sticky ordering faults and a reference-select-without-background fault, so software misuse shows up in read-back
  always_comb begin
    fault_set = '0;
    fault_set[FLT_CFG_WHILE_RUN] = wr && run && (paddr == CFG_A_ADDR || paddr == CFG_B_ADDR || paddr == AVG_ADDR);
    fault_set[FLT_LINK_BEFORE_RUN] = wr && paddr == LINK_CTRL_ADDR && wbyte[LINK_BIT] && !run;
    fault_set[FLT_RUN_OFF_LINK_ON] = wr && paddr == RUN_CTRL_ADDR && !wbyte[RUN_BIT] && link;
    fault_set[FLT_OFFSET_REFERENCE_SELECT_NO_BG] = run && cfg_live.offset_reference_select && !cfg_live.bg;
  end

  // Write one to clear; a new event in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) fault_q <= '0;
    else if (wr && paddr == FAULT_ADDR) fault_q <= (fault_q & ~wbyte[FLT_W-1:0]) | fault_set;
    else fault_q <= fault_q | fault_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      engine_hold_q <= 1'b0;
    end else begin
      engine_hold_q <= !run;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) divider_reset_q <= 1'b0;
    else divider_reset_q <= !run;
  end

  // Link is never driven while calibration is held, whatever software wrote
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) link_out_q <= 1'b0;
    else link_out_q <= link && run;
  end

  assign engine_hold = engine_hold_q;
  assign divider_reset = divider_reset_q;
  assign serial_link_enable = link_out_q;

  acc_cal_sequencer u_seq (
    .pclk(pclk),
    .presetn(presetn),
    .run(run),
    .cfg(cfg_live),
    .fg_done_in(fg_done_in),
    .engine_ctrl(engine_ctrl),
    .cfg_latched(engine_cfg),
    .state(seq_state),
    .fg_done(seq_fg_done)
  );

  always_comb begin
    rd_mux = '0;
    unique case (paddr)
      RUN_CTRL_ADDR: rd_mux[7:0] = run_ctrl_q;
      CFG_A_ADDR: rd_mux[7:0] = cfg_a_q;
      CFG_B_ADDR: rd_mux[7:0] = cfg_b_q;
      AVG_ADDR: rd_mux[7:0] = avg_q;
      LINK_CTRL_ADDR: rd_mux[7:0] = link_ctrl_q;
      STATUS_ADDR: rd_mux[7:0] = {2'b00, link_out_q, engine_hold_q, seq_fg_done, seq_state};
      FAULT_ADDR: rd_mux[FLT_W-1:0] = fault_q;
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata_q <= '0;
    else if (setup && !pwrite) prdata_q <= rd_mux;
  end

endmodule : acc_calibration_control

// File: verif/acc_cal_properties.sv
module acc_cal_properties
  import acc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic engine_hold,
  input wire logic divider_reset,
  input wire logic serial_link_enable,
  input acc_engine_t engine_ctrl,
  input acc_cfg_t engine_cfg
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking
    @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_run_clear;
    psel && penable && pwrite && pstrb[0] && paddr == RUN_CTRL_ADDR && !pwdata[0];
  endsequence
  sequence s_fg_start;
    engine_ctrl.values_reset && engine_cfg.fg;
  endsequence
  a_hold_after_clear: assert property (s_run_clear |-> ##2 engine_hold)
    else $error("engine hold not raised after run clear");
  a_divider_with_hold: assert property (divider_reset == engine_hold)
    else $error("divider reset differs from engine hold");
  a_link_needs_run: assert property (serial_link_enable |-> !engine_hold)
    else $error("serial link enabled while engine held");
  a_values_reset_pulse: assert property (engine_ctrl.values_reset |=> !engine_ctrl.values_reset)
    else $error("values reset longer than one cycle");
  a_fg_follows_reset: assert property (s_fg_start |=> engine_ctrl.fg_run)
    else $error("foreground did not follow values reset");
  a_bg_run_gated: assert property (engine_ctrl.bg_run |-> engine_cfg.bg)
    else $error("background runs without select");
  a_fg_offset_gated: assert property (engine_ctrl.fg_offset |-> engine_cfg.fg && engine_cfg.fg_os)
    else $error("foreground offset without its selects");
  a_bg_offset_gated: assert property (engine_ctrl.bg_offset |-> engine_cfg.bg && engine_cfg.bg_os)
    else $error("background offset without its selects");
  a_spare_ref_gated: assert property (engine_ctrl.ref_spare |-> engine_cfg.offset_reference_select && engine_cfg.bg)
    else $error("spare reference without select");
  a_cfg_held_in_run: assert property (engine_ctrl.bg_run |=> $stable(engine_cfg))
    else $error("latched configuration moved while running");
endmodule : acc_cal_properties

bind acc_calibration_control acc_cal_properties i_acc_cal_properties (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .pstrb(pstrb),
  .engine_hold(engine_hold),
  .divider_reset(divider_reset),
  .serial_link_enable(serial_link_enable),
  .engine_ctrl(engine_ctrl),
  .engine_cfg(engine_cfg)
);

// File: verif/test_acc_calibration_control.sv
module test_acc_calibration_control
  import acc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fg_done_in;
  logic engine_hold, divider_reset, serial_link_enable, e;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [7:0] r;
  acc_engine_t engine_ctrl;
  acc_cfg_t engine_cfg;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [ADDR_W-1:0] ra [5] = '{RUN_CTRL_ADDR, CFG_A_ADDR, CFG_B_ADDR, AVG_ADDR, LINK_CTRL_ADDR};
  logic [7:0] rv [5] = '{8'h01, 8'h01, 8'h01, 8'h61, 8'h00};
  acc_calibration_control i_acc_calibration_control (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fg_done_in(fg_done_in), .engine_hold(engine_hold),
    .divider_reset(divider_reset), .serial_link_enable(serial_link_enable), .engine_ctrl(engine_ctrl),
    .engine_cfg(engine_cfg));
  initial begin
    pclk = 0;
    forever #10 pclk = ~pclk;
  end
  task finish_test;
    if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  // Timeout well above the hundred or so cycles the sequence needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      finish_test();
    end
  end
  task chk(input string n, input logic [15:0] x, input logic [15:0] g);
    n_tests++;
    if (g !== x) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : settle
  initial begin
    {psel, penable, pwrite, fg_done_in, presetn} = 5'h00;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hF;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ra[i], 8'h00);
      chk("reset value", 16'(rv[i]), 16'(r));
    end
    chk("fg_run", 16'h0001, 16'(engine_ctrl.fg_run));
    apb(1'b0, STATUS_ADDR, 8'h00);
    chk("status fg busy", 16'h0002, 16'(r));
    @(posedge pclk) fg_done_in <= 1'b1;
    @(posedge pclk) fg_done_in <= 1'b0;
    apb(1'b0, STATUS_ADDR, 8'h00);
    chk("status", 16'h000C, 16'(r));
    apb(1'b1, LINK_CTRL_ADDR, 8'h01);
    settle(2);
    chk("link on", 16'h0001, 16'(serial_link_enable));
    apb(1'b1, LINK_CTRL_ADDR, 8'h00);
    apb(1'b1, RUN_CTRL_ADDR, 8'h00);
    settle(2);
    chk("held", 16'h0007, 16'({engine_hold, divider_reset, ~serial_link_enable}));
    apb(1'b1, CFG_A_ADDR, 8'h0E);
    apb(1'b1, CFG_B_ADDR, 8'h05);
    apb(1'b1, AVG_ADDR, 8'h35);
    apb(1'b0, CFG_A_ADDR, 8'h00);
    chk("cfg_a", 16'h000E, 16'(r));
    apb(1'b0, CFG_B_ADDR, 8'h00);
    chk("cfg_b", 16'h0005, 16'(r));
    apb(1'b1, RUN_CTRL_ADDR, 8'h01);
    settle(5);
    chk("engine_ctrl", 16'h0007, 16'(engine_ctrl));
    chk("engine_cfg", 16'h03DD, 16'(engine_cfg));
    chk("running", 16'h0000, 16'(engine_hold));
    // Foreground with offset, then background with spare reference
    apb(1'b1, RUN_CTRL_ADDR, 8'h00);
    apb(1'b1, CFG_A_ADDR, 8'h07);
    apb(1'b1, RUN_CTRL_ADDR, 8'h01);
    settle(3);
    chk("fg offset ctrl", 16'h0019, 16'(engine_ctrl));
    chk("fg offset cfg", 16'h075D, 16'(engine_cfg));
    @(posedge pclk) fg_done_in <= 1'b1;
    @(posedge pclk) fg_done_in <= 1'b0;
    settle(1);
    chk("bg after fg", 16'h0005, 16'(engine_ctrl));
    apb(1'b0, STATUS_ADDR, 8'h00);
    chk("status bg", 16'h000B, 16'(r));
    apb(1'b0, FAULT_ADDR, 8'h00);
    chk("faults", 16'h0000, 16'(r));
    apb(1'b0, 12'h000, 8'h00);
    chk("unmapped", 16'h0100, {7'h00, e, r});
    finish_test();
  end
endmodule : test_acc_calibration_control
